// file: hw/data_port_pkg.sv
// Functional notes
// - Read data sampled only while response valid.
// - Error input counts only with response valid.
// - Write indication high for writes, with request.
// - Write data presented together with request.
// - Checksum protects address phase of each request.
`default_nettype none
package data_port_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int CHK_W = 13;
  localparam int FIFO_DEPTH = 4;
  localparam int MAX_OUTSTANDING = 4;
  localparam logic [CHK_W-1:0] CHK_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [3:0] be;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic err;
    logic perr;
    logic we;
  } rsp_t;
endpackage
`default_nettype wire

// file: hw/req_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic push, pop;
  logic ready_reg, ready_next;

  // Ready is registered from the next count so the issuer sees a flop.
  assign in_ready = ready_reg;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wp_next = (wp_reg == PW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
    end
    if (pop) begin
      rp_next = (rp_reg == PW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
    ready_next = (cnt_next != (PW+1)'(DEPTH));
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// file: hw/core_data_port.sv
`timescale 1ns/10ps
`default_nettype none
module core_data_port
  import data_port_pkg::*;
#(
  parameter int MAX_OUT = MAX_OUTSTANDING
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [$bits(req_t)-1:0] cmd,
  output logic data_req,
  input wire logic data_gnt,
  output logic [ADDR_W-1:0] data_addr,
  output logic [3:0] data_be,
  output logic data_we,
  output logic [DATA_W-1:0] data_wdata,
  output logic [CHK_W-1:0] data_achk,
  input wire logic data_rvalid,
  input wire logic data_rvalidpar,
  input wire logic [DATA_W-1:0] data_rdata,
  input wire logic data_err,
  output logic rsp_valid,
  output logic [$bits(rsp_t)-1:0] rsp,
  output logic protocol_err
);
  // Requests queue here so the issuer stalls only once the queue is full.
  logic q_valid, q_ready;
  req_t q_data;
  req_fifo #(.WIDTH($bits(req_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  typedef enum logic [0:0] {IDLE, REQ} st_t;
  localparam int OW = $clog2(MAX_OUT + 1);

  // Control group: where the request phase stands.
  st_t st_reg, st_next;
  logic req_reg, req_next;

  // Payload group: the fields that travel with the request.
  logic we_reg, we_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [3:0] be_reg, be_next;
  logic [DATA_W-1:0] wd_reg, wd_next;
  logic [CHK_W-1:0] chk_reg, chk_next;

  // Outstanding group: accesses awaiting a response, one write flag per access.
  logic [OW-1:0] out_reg, out_next;
  logic [MAX_OUT-1:0] wq_reg, wq_next;

  // Response group and the sticky link fault.
  logic rv_reg, rv_next;
  rsp_t rsp_reg, rsp_next;
  logic perr_reg, perr_next;

  logic issue;
  logic accepted;
  logic retire;
  logic stray;
  logic par_bad;
  logic [3:0] addr_par;
  logic [CHK_W-1:0] chk_new;

  // One parity bit per address byte.
  for (genvar g = 0; g < 4; g = g + 1) begin : g_addr_par
    assign addr_par[g] = ^q_data.addr[g*8 +: 8];
  end

  // Odd parity on every group keeps an all-zero bus detectable.
  assign chk_new = ~{{(CHK_W-6){1'b0}}, q_data.we, ^q_data.be, addr_par};

  assign issue = q_valid && q_ready;
  assign accepted = req_reg && data_gnt;
  // A pulse with nothing outstanding is stray and retires nothing.
  assign retire = data_rvalid && (out_reg != '0);
  assign stray = data_rvalid && (out_reg == '0);
  // The parity companion must always be the inverse of the pulse.
  assign par_bad = data_rvalid == data_rvalidpar;
  assign q_ready = (st_reg == IDLE) && (out_reg < OW'(MAX_OUT));

  always_comb begin
    st_next = st_reg;
    req_next = req_reg;
    case (st_reg)
      IDLE: begin
        if (issue) begin
          req_next = 1'b1;
          st_next = REQ;
        end
      end
      REQ: begin
        // The request stands until the grant.
        if (accepted) begin
          req_next = 1'b0;
          st_next = IDLE;
        end
      end
      default: begin
        req_next = 1'b0;
        st_next = IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= IDLE;
      req_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      req_reg <= req_next;
    end
  end

  // The payload loads only when a request is issued, so it stays stable until the grant.
  always_comb begin
    we_next = we_reg;
    addr_next = addr_reg;
    be_next = be_reg;
    wd_next = wd_reg;
    chk_next = chk_reg;
    if (issue) begin
      we_next = q_data.we;
      addr_next = q_data.addr;
      be_next = q_data.be;
      wd_next = q_data.wdata;
      chk_next = chk_new;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      we_reg <= 1'b0;
      addr_reg <= '0;
      be_reg <= '0;
      wd_reg <= DATA_RESET;
      chk_reg <= CHK_RESET;
    end else begin
      we_reg <= we_next;
      addr_reg <= addr_next;
      be_reg <= be_next;
      wd_reg <= wd_next;
      chk_reg <= chk_next;
    end
  end

  // A response pulse retires the oldest outstanding access.
  always_comb begin
    out_next = out_reg + OW'(accepted) - OW'(retire);
    wq_next = wq_reg;
    if (accepted) begin
      wq_next = wq_next | (MAX_OUT'(we_reg) << out_reg);
    end
    if (retire) begin
      wq_next = wq_next >> 1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      out_reg <= '0;
      wq_reg <= '0;
    end else begin
      out_reg <= out_next;
      wq_reg <= wq_next;
    end
  end

  always_comb begin
    rv_next = 1'b0;
    rsp_next = rsp_reg;
    if (retire) begin
      rv_next = 1'b1;
      rsp_next.we = wq_reg[0];
      // Read data is taken only in the pulse cycle; a write reports zero.
      rsp_next.rdata = wq_reg[0] ? DATA_RESET : data_rdata;
      rsp_next.err = data_err;
      rsp_next.perr = par_bad;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rv_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      rv_reg <= rv_next;
      rsp_reg <= rsp_next;
    end
  end

  // Parity mismatch or a stray pulse is sticky until reset.
  always_comb begin
    perr_next = perr_reg;
    if (par_bad || stray) begin
      perr_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      perr_reg <= 1'b0;
    end else begin
      perr_reg <= perr_next;
    end
  end

  assign data_req = req_reg;
  assign data_we = we_reg;
  assign data_addr = addr_reg;
  assign data_be = be_reg;
  assign data_wdata = wd_reg;
  assign data_achk = chk_reg;
  assign rsp_valid = rv_reg;
  assign rsp = rsp_reg;
  assign protocol_err = perr_reg;
endmodule
`default_nettype wire

// file: test/core_data_port_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module core_data_port_monitor import data_port_pkg::*; (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic data_req,
  input wire logic data_gnt,
  input wire logic data_we,
  input wire logic data_rvalid,
  input wire logic data_rvalidpar,
  input wire logic data_err,
  input wire logic rsp_valid,
  input wire logic protocol_err,
  input wire logic [ADDR_W-1:0] data_addr,
  input wire logic [DATA_W-1:0] data_wdata,
  input wire logic [DATA_W-1:0] data_rdata,
  input wire logic [3:0] data_be,
  input wire logic [CHK_W-1:0] data_achk,
  input wire logic [$bits(rsp_t)-1:0] rsp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_wait;
    data_req && !data_gnt;
  endsequence
  a_req_fields_hold: assert property (s_wait |=> data_req && $stable({data_addr, data_we, data_wdata}))
    else $error("request fields moved before grant");
  a_chk_we_bit: assert property (data_req |-> data_achk[5] == ~data_we)
    else $error("checksum write bit wrong");
  a_chk_be_bit: assert property (data_req |-> data_achk[4] == ~^data_be)
    else $error("checksum enable bit wrong");
  a_chk_addr_bits: assert property (data_req |-> data_achk[3:0] == ~{^data_addr[31:24], ^data_addr[23:16],
    ^data_addr[15:8], ^data_addr[7:0]} && &data_achk[12:6]) else $error("checksum address bits wrong");
  a_rsp_after_valid: assert property (rsp_valid |-> $past(data_rvalid))
    else $error("response without memory pulse");
  a_rsp_read_data: assert property (rsp_valid |-> rsp[34:3] == (rsp[0] ? 32'h0 : $past(data_rdata)))
    else $error("response data wrong");
  a_rsp_err_flag: assert property (rsp_valid |-> rsp[2] == $past(data_err))
    else $error("response error flag wrong");
  a_parity_flags: assert property (data_rvalidpar == data_rvalid |=> protocol_err)
    else $error("parity fault not flagged");
endmodule
bind core_data_port core_data_port_monitor mon (.*);
`default_nettype wire

// file: test/mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic data_req,
  input wire logic data_we,
  input wire logic slow,
  input wire logic err_inj,
  input wire logic bad_par,
  input wire logic [31:0] data_addr,
  input wire logic [31:0] data_wdata,
  output logic data_gnt,
  output logic data_rvalid,
  output logic data_rvalidpar,
  output logic data_err,
  output logic [31:0] data_rdata
);
  logic [31:0] mem [16];
  logic [32:0] pend [$];
  int wait_n;
  assign data_gnt = data_req && (!slow || wait_n == 3);
  assign data_rvalidpar = bad_par ? data_rvalid : ~data_rvalid;
  // Idle lines show the inverse of their last value so stale data never looks valid.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      data_rvalid <= 1'b0;
      data_err <= 1'b0;
      data_rdata <= 32'hffffffff;
      wait_n <= 0;
      pend.delete();
    end else begin
      wait_n <= (data_req && !data_gnt) ? wait_n + 1 : 0;
      if (pend.size() > 0 && !data_rvalid) begin
        {data_err, data_rdata} <= pend.pop_front();
        data_rvalid <= 1'b1;
      end else begin
        data_rvalid <= 1'b0;
        {data_err, data_rdata} <= ~{data_err, data_rdata};
      end
      if (data_gnt) begin
        if (data_we) mem[data_addr[5:2]] = data_wdata;
        pend.push_back({err_inj, mem[data_addr[5:2]]});
      end
    end
  end
endmodule
`default_nettype wire

// file: test/core_data_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module core_data_port_tb_top;
  import data_port_pkg::*;
  logic sys_clk = 0, rstn = 0, cmd_valid = 0, slow = 0, err_inj = 0, bad_par = 0, saw_full = 0;
  logic [$bits(req_t)-1:0] cmd = '0;
  logic cmd_ready, data_req, data_gnt, data_we, data_rvalid, data_rvalidpar, data_err, rsp_valid, protocol_err;
  logic [31:0] data_addr, data_wdata, data_rdata;
  logic [3:0] data_be;
  logic [CHK_W-1:0] data_achk;
  logic [$bits(rsp_t)-1:0] rsp;
  logic [34:0] got [$];
  int fail_count = 0, comparisons = 0;
  always #10 sys_clk = ~sys_clk;
  core_data_port dut (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .data_req(data_req), .data_gnt(data_gnt), .data_addr(data_addr), .data_be(data_be), .data_we(data_we),
    .data_wdata(data_wdata), .data_achk(data_achk), .data_rvalid(data_rvalid), .data_rvalidpar(data_rvalidpar),
    .data_rdata(data_rdata), .data_err(data_err), .rsp_valid(rsp_valid), .rsp(rsp), .protocol_err(protocol_err));
  mem_model mem (.sys_clk(sys_clk), .rstn(rstn), .data_req(data_req), .data_we(data_we), .slow(slow),
    .err_inj(err_inj), .bad_par(bad_par), .data_addr(data_addr), .data_wdata(data_wdata), .data_gnt(data_gnt),
    .data_rvalid(data_rvalid), .data_rvalidpar(data_rvalidpar), .data_err(data_err), .data_rdata(data_rdata));
  always @(posedge sys_clk) begin
    if (rsp_valid) got.push_back(rsp);
    if (cmd_valid && !cmd_ready) saw_full = 1;
  end
  task automatic chk(input string what, input logic [34:0] e, input logic [34:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic send(input logic we, input logic [31:0] a, input logic [31:0] d);
    cmd_valid = 1;
    cmd = {we, a, 4'hf, d};
    while (!cmd_ready) @(posedge sys_clk) #1;
    @(posedge sys_clk) #1;
  endtask
  task automatic take(input logic [31:0] d, input logic e, input logic we);
    int n;
    cmd_valid = 0;
    for (n = 0; n < 200 && got.size() == 0; n++) @(posedge sys_clk) #1;
    chk("response", {d, e, 1'b0, we}, got.size() > 0 ? got.pop_front() : 'x);
  endtask
  task automatic t_write_read;
    send(1, 32'h00000014, 32'h5a5a0f0f);
    send(0, 32'h00000014, 32'h0);
    take(32'h0, 0, 1);
    take(32'h5a5a0f0f, 0, 0);
    $display("write then read done");
  endtask
  task automatic t_fill_order;
    int i;
    slow = 1;
    for (i = 0; i < 7; i++) send(1, i * 4, 32'h11110000 + i);
    slow = 0;
    for (i = 0; i < 7; i++) send(0, i * 4, 32'h0);
    for (i = 0; i < 7; i++) take(32'h0, 0, 1);
    for (i = 0; i < 7; i++) take(32'h11110000 + i, 0, 0);
    chk("queue refused", 1, saw_full);
    $display("fill and order done");
  endtask
  task automatic t_error;
    err_inj = 1;
    // The model samples the flag at the grant, which comes only after the queue takes the command.
    send(0, 32'h00000004, 32'h0);
    take(32'h11110001, 1, 0);
    err_inj = 0;
    $display("error response done");
  endtask
  task automatic t_parity;
    chk("no fault yet", 0, protocol_err);
    bad_par = 1;
    @(posedge sys_clk) #1 bad_par = 0;
    @(posedge sys_clk) #1 chk("parity fault", 1, protocol_err);
    $display("parity fault done");
  endtask
  task automatic t_reset;
    rstn = 0;
    repeat (2) @(posedge sys_clk);
    #1 rstn = 1;
    @(posedge sys_clk) #1;
    chk("fault cleared", 0, protocol_err);
    chk("ready after reset", 1, cmd_ready);
    send(1, 32'h00000008, 32'h0badcafe);
    send(0, 32'h00000008, 32'h0);
    take(32'h0, 0, 1);
    take(32'h0badcafe, 0, 0);
    $display("mid-run reset done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 rstn = 1;
    t_write_read;
    t_fill_order;
    t_error;
    t_parity;
    t_reset;
    give_verdict;
  end
endmodule
`default_nettype wire
